// ==== rtu_pkg.sv ====
// Package: register map, field layout, reset values and clock figures
package rtu_pkg;

  // ***************************************************************
  // Register indices (byte address is four times the index)
  // ***************************************************************
  localparam logic [7:0] IDX_MODE_PRESC_HIGH = 8'h2a;
  localparam logic [7:0] IDX_PRESC_LOW = 8'h2b;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'h2c;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'h2d;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h2e;
  localparam logic [7:0] IDX_COUNT_LOW = 8'h2f;
  localparam logic [7:0] IDX_CONTROL = 8'h30;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h31;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h32;

  localparam int ADDR_W = 10;
  localparam int IRQ_W = 2;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int MODE_AUTO_BIT = 7;
  localparam int MODE_RESTART_BIT = 4;
  localparam int MODE_PRESC_MSB = 3;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_ACTIVE_BIT = 2;
  localparam int IRQ_EXPIRY_BIT = 0;
  localparam int IRQ_START_BIT = 1;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [11:0] RST_PRESC = 12'h000;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;

  // ***************************************************************
  // Clock figures
  // ***************************************************************
  localparam int REF_HZ = 125000000;
  localparam int XTAL_HZ = 27120000;
  localparam int TIMER_HZ = 13560000;
  localparam int RATE_GCD = 10000;
  localparam int XTAL_STEP = XTAL_HZ / RATE_GCD;
  localparam int XTAL_MOD = REF_HZ / RATE_GCD;

endpackage

// ==== rtu_cnt_if.sv ====
// Interface between register front end and the timer core
`timescale 1ns/1ps
`default_nettype none
interface rtu_cnt_if #(
  parameter int PRESC_W = 12,
  parameter int COUNT_W = 16
);
  logic start;
  logic stop;
  logic auto_restart;
  logic [PRESC_W-1:0] presc_reload;
  logic [COUNT_W-1:0] count_reload;
  logic [COUNT_W-1:0] count;
  logic running;
  logic expire;

  modport ctl (
    output start, stop, auto_restart, presc_reload, count_reload,
    input count, running, expire
  );
  modport core (
    input start, stop, auto_restart, presc_reload, count_reload,
    output count, running, expire
  );
endinterface
`default_nettype wire

// ==== rtu_clk_div.sv ====
// Fractional divider: 27.12 MHz enable, halved into a 13.56 MHz tick
`timescale 1ns/1ps
`default_nettype none
module rtu_clk_div (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  output logic o_tick
);
  localparam logic [14:0] STEP = 15'(rtu_pkg::XTAL_STEP);
  localparam logic [14:0] MODV = 15'(rtu_pkg::XTAL_MOD);

  logic [14:0] acc;
  logic half;
  wire [14:0] sum = acc + STEP;
  wire xtal_en = (sum >= MODV);
  wire [14:0] next_acc = xtal_en ? (sum - MODV) : sum;

  // Phase accumulator keeps the long-run rate exact; jitter is one
  // reference period, which the timer cannot see
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      acc <= 15'h0000;
      half <= 1'b0;
    end else begin
      acc <= next_acc;
      if (xtal_en) begin
        half <= ~half;
      end
    end
  end

  assign o_tick = xtal_en & half;
endmodule
`default_nettype wire

// ==== rtu_counter.sv ====
// Timer core: prescaler stage cascaded into the main down-counter
`timescale 1ns/1ps
`default_nettype none
module rtu_counter #(
  parameter int PRESC_W = 12,
  parameter int COUNT_W = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_tick,
  rtu_cnt_if.core cnt
);
  // One step is 2*P+1 ticks, so the stage needs one extra bit
  logic [PRESC_W:0] presc;
  logic [COUNT_W-1:0] count;
  logic running;
  logic expire;

  wire [PRESC_W:0] step_len = {cnt.presc_reload, 1'b0};
  // Reaching zero leaves only the one extra tick before expiry
  wire last_step = (count == COUNT_W'(1));
  wire [PRESC_W:0] load_len = (cnt.count_reload == '0) ? '0 : step_len;
  wire step_done = (presc == '0);
  wire at_zero = (count == '0);
  wire fire = running & i_tick & step_done & at_zero;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presc <= '0;
      count <= '0;
      running <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= fire;
      if (cnt.start) begin
        presc <= load_len;
        count <= cnt.count_reload;
        running <= 1'b1;
      end else if (cnt.stop) begin
        running <= 1'b0;
      end else if (running && i_tick) begin
        if (!step_done) begin
          presc <= presc - 1'b1;
        end else if (!at_zero) begin
          presc <= last_step ? '0 : step_len;
          count <= count - 1'b1;
        end else if (cnt.auto_restart) begin
          presc <= load_len;
          count <= cnt.count_reload;
        end else begin
          running <= 1'b0;
        end
      end
    end
  end

  assign cnt.count = count;
  assign cnt.running = running;
  assign cnt.expire = expire;
endmodule
`default_nettype wire

// ==== rtu_timer.sv ====
// Timer unit top: APB register file, interrupts, auto-start, core
//
// Contract
// - The timer runs from a 13.56 MHz tick made by halving 27.12 MHz.
// - A 12-bit prescaler stage advances the main counter stage.
// - The prescaler reload spans 0..4095, split over two registers.
// - The main reload is 16 bits, 0..65535, in two register bytes.
// - One counter step lasts 2*prescaler+1 input clock periods.
// - The interval is step length times steps from reload, plus one.
// - With auto start set, end of transmission starts the timer.
// - The counter runs down from the reload and its value is readable.
// - Expiry of the down-counter raises the timer interrupt request.
// - The active indication holds from start until stop or expiry; with auto restart set, it stays high through expiry.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rtu_timer #(
  parameter int PRESC_W = 12,
  parameter int COUNT_W = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [rtu_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_tx_end,
  output logic o_expiry_irq,
  output logic o_count_active
);

  // ***************************************************************
  // Stored registers
  // ***************************************************************
  logic auto_start;
  logic auto_restart;
  logic [PRESC_W-1:0] presc_reload;
  logic [COUNT_W-1:0] count_reload;
  logic [rtu_pkg::IRQ_W-1:0] irq_status;
  logic [rtu_pkg::IRQ_W-1:0] irq_mask;
  logic [7:0] count_low_shadow;
  logic [31:0] prdata;
  logic pslverr;
  logic start_pulse;
  logic stop_pulse;

  // ***************************************************************
  // Core and tick divider
  // ***************************************************************
  rtu_cnt_if #(
    .PRESC_W(PRESC_W),
    .COUNT_W(COUNT_W)
  ) cnt_bus ();

  logic tick;

  rtu_clk_div u_div (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .o_tick(tick)
  );

  rtu_counter #(
    .PRESC_W(PRESC_W),
    .COUNT_W(COUNT_W)
  ) u_core (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_tick(tick),
    .cnt(cnt_bus.core)
  );

  // ***************************************************************
  // APB decode
  // ***************************************************************
  wire [7:0] word_idx = i_paddr[rtu_pkg::ADDR_W-1:2];
  wire setup = i_psel & ~i_penable;
  wire access = i_psel & i_penable;
  wire wr_en = access & i_pwrite & i_pstrb[0];
  wire [7:0] wbyte = i_pwdata[7:0];

  wire sel_mode = (word_idx == rtu_pkg::IDX_MODE_PRESC_HIGH);
  wire sel_presc = (word_idx == rtu_pkg::IDX_PRESC_LOW);
  wire sel_rel_hi = (word_idx == rtu_pkg::IDX_RELOAD_HIGH);
  wire sel_rel_lo = (word_idx == rtu_pkg::IDX_RELOAD_LOW);
  wire sel_cnt_hi = (word_idx == rtu_pkg::IDX_COUNT_HIGH);
  wire sel_cnt_lo = (word_idx == rtu_pkg::IDX_COUNT_LOW);
  wire sel_ctrl = (word_idx == rtu_pkg::IDX_CONTROL);
  wire sel_stat = (word_idx == rtu_pkg::IDX_IRQ_STATUS);
  wire sel_mask = (word_idx == rtu_pkg::IDX_IRQ_MASK);
  wire mapped = (sel_mode | sel_presc | sel_rel_hi | sel_rel_lo |
                 sel_cnt_hi | sel_cnt_lo | sel_ctrl | sel_stat |
                 sel_mask) & (i_paddr[1:0] == 2'h0);

  // ***************************************************************
  // Read data selection
  // ***************************************************************
  wire [7:0] rd_mode = {auto_start, 2'h0, auto_restart,
                        presc_reload[PRESC_W-1:8]};
  wire [7:0] rd_ctrl = {5'h00, cnt_bus.running, 2'h0};
  wire [7:0] rd_byte =
    sel_mode ? rd_mode :
    sel_presc ? presc_reload[7:0] :
    sel_rel_hi ? count_reload[15:8] :
    sel_rel_lo ? count_reload[7:0] :
    sel_cnt_hi ? cnt_bus.count[15:8] :
    sel_cnt_lo ? count_low_shadow :
    sel_ctrl ? rd_ctrl :
    sel_stat ? {6'h00, irq_status} :
    sel_mask ? {6'h00, irq_mask} :
    8'h00;

  // Read data is latched in the setup phase, so no wait state is needed
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= {24'h000000, rd_byte};
      pslverr <= ~mapped;
    end
  end

  assign o_pready = 1'b1;
  assign o_prdata = prdata;
  assign o_pslverr = pslverr & access;

  // ***************************************************************
  // Count read snapshot
  // ***************************************************************
  // The low byte follows the count and holds only while a low-byte
  // read is selected, so a high-then-low read pair can tear across a borrow
  wire rd_cnt_hi = setup & ~i_pwrite & sel_cnt_hi;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_low_shadow <= 8'h00;
    end else if (rd_cnt_hi) begin
      count_low_shadow <= cnt_bus.count[7:0];
    end else if (!(i_psel & sel_cnt_lo)) begin
      count_low_shadow <= cnt_bus.count[7:0];
    end
  end

  // ***************************************************************
  // Configuration writes
  // ***************************************************************
  wire wr_mode = wr_en & sel_mode & (i_paddr[1:0] == 2'h0);
  wire wr_presc = wr_en & sel_presc & (i_paddr[1:0] == 2'h0);
  wire wr_rel_hi = wr_en & sel_rel_hi & (i_paddr[1:0] == 2'h0);
  wire wr_rel_lo = wr_en & sel_rel_lo & (i_paddr[1:0] == 2'h0);
  wire wr_ctrl = wr_en & sel_ctrl & (i_paddr[1:0] == 2'h0);
  wire wr_stat = wr_en & sel_stat & (i_paddr[1:0] == 2'h0);
  wire wr_mask = wr_en & sel_mask & (i_paddr[1:0] == 2'h0);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      auto_start <= rtu_pkg::RST_MODE[rtu_pkg::MODE_AUTO_BIT];
      auto_restart <= rtu_pkg::RST_MODE[rtu_pkg::MODE_RESTART_BIT];
      presc_reload <= rtu_pkg::RST_PRESC;
    end else if (wr_mode) begin
      auto_start <= wbyte[rtu_pkg::MODE_AUTO_BIT];
      auto_restart <= wbyte[rtu_pkg::MODE_RESTART_BIT];
      presc_reload[PRESC_W-1:8] <= wbyte[rtu_pkg::MODE_PRESC_MSB:0];
    end else if (wr_presc) begin
      presc_reload[7:0] <= wbyte;
    end
  end

  // Loads take effect at the next start; a change mid-count is
  // picked up at the next step (prescaler) or auto restart (count)
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_reload <= rtu_pkg::RST_RELOAD;
    end else if (wr_rel_hi) begin
      count_reload[15:8] <= wbyte;
    end else if (wr_rel_lo) begin
      count_reload[7:0] <= wbyte;
    end
  end

  // ***************************************************************
  // Start and stop
  // ***************************************************************
  wire host_start = wr_ctrl & wbyte[rtu_pkg::CTRL_START_BIT];
  wire host_stop = wr_ctrl & wbyte[rtu_pkg::CTRL_STOP_BIT];
  wire auto_go = auto_start & i_tx_end;
  wire next_start = host_start | auto_go;
  wire next_stop = host_stop & ~next_start;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      start_pulse <= 1'b0;
      stop_pulse <= 1'b0;
    end else begin
      start_pulse <= next_start;
      stop_pulse <= next_stop;
    end
  end

  assign cnt_bus.start = start_pulse;
  assign cnt_bus.stop = stop_pulse;
  assign cnt_bus.auto_restart = auto_restart;
  assign cnt_bus.presc_reload = presc_reload;
  assign cnt_bus.count_reload = count_reload;

  // ***************************************************************
  // Interrupt status and mask
  // ***************************************************************
  wire [rtu_pkg::IRQ_W-1:0] irq_set = {start_pulse, cnt_bus.expire};
  wire [rtu_pkg::IRQ_W-1:0] irq_clr =
    wr_stat ? wbyte[rtu_pkg::IRQ_W-1:0] : '0;
  // Set wins over a clear in the same cycle
  wire [rtu_pkg::IRQ_W-1:0] next_irq_status =
    (irq_status & ~irq_clr) | irq_set;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_status <= '0;
      irq_mask <= rtu_pkg::RST_IRQ_MASK;
    end else begin
      irq_status <= next_irq_status;
      if (wr_mask) begin
        irq_mask <= wbyte[rtu_pkg::IRQ_W-1:0];
      end
    end
  end

  assign o_expiry_irq = |(irq_status & irq_mask);
  assign o_count_active = cnt_bus.running;

endmodule
`default_nettype wire

// ==== rtu_timer_sva.sv ====
// Port-level checks for the timer unit
`timescale 1ns/1ps
`default_nettype none
module rtu_timer_sva #(
  parameter int PRESC_W = 12,
  parameter int COUNT_W = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [rtu_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_tx_end,
  input wire logic o_expiry_irq,
  input wire logic o_count_active
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  wire acc = i_psel && i_penable;
  wire wr0 = acc && i_pwrite && i_pstrb[0];
  wire ctl_wr = wr0 && i_paddr == {rtu_pkg::IDX_CONTROL, 2'b00};
  wire msk_wr = wr0 && i_paddr == {rtu_pkg::IDX_IRQ_MASK, 2'b00};
  wire [7:0] idx = i_paddr[9:2];
  wire mapped = idx >= 8'h2a && idx <= 8'h32 && i_paddr[1:0] == 2'b00;
  // ********
  // Bus
  // ********
  a_ready_high: assert property (i_psel |-> o_pready)
    else $error("pready low in a transfer");
  a_err_access: assert property (o_pslverr |-> acc)
    else $error("pslverr outside access");
  a_err_unmapped: assert property (acc && !mapped |-> o_pslverr)
    else $error("no pslverr on bad address");
  a_rdata_hold: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
    else $error("read data moved outside setup");
  // ********
  // Timer
  // ********
  a_start_active: assert property (ctl_wr && i_pwdata[0] |-> ##[2:3] o_count_active)
    else $error("start did not raise active");
  a_stop_idle: assert property (ctl_wr && i_pwdata[1:0] == 2'b10 |-> ##[1:3] !o_count_active)
    else $error("stop did not clear active");
  a_mask_off: assert property (msk_wr && i_pwdata[1:0] == 2'b00 |=> !o_expiry_irq)
    else $error("irq high with mask cleared");
  a_rise_cause: assert property ($rose(o_count_active) |->
    $past(ctl_wr, 2) || $past(ctl_wr, 3) || $past(i_tx_end, 2) || $past(i_tx_end, 3))
    else $error("active rose without a start");
  c_expire: cover property ($fell(o_count_active));
  c_irq: cover property ($rose(o_expiry_irq));
  c_err: cover property (o_pslverr);
endmodule
bind rtu_timer rtu_timer_sva #(.PRESC_W(PRESC_W), .COUNT_W(COUNT_W)) u_sva (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_tx_end(i_tx_end),
  .o_expiry_irq(o_expiry_irq), .o_count_active(o_count_active));
`default_nettype wire

// ==== rtu_host_model.sv ====
// Host controller model: APB master and end-of-frame source
`timescale 1ns/1ps
`default_nettype none
module rtu_host_model (
  input wire logic i_clk,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [9:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic [3:0] o_pstrb,
  output logic o_tx_end
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 10'h0;
    o_pwdata = 32'h0;
    o_pstrb = 4'hf;
    o_tx_end = 1'b0;
  end
  task automatic xfer(input logic w, input logic [9:0] a,
      input logic [7:0] wd, output logic [7:0] d, output logic e);
    @(posedge i_clk);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= {24'h0, wd};
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    d = i_prdata[7:0];
    e = i_pslverr;
    // Idle address and data lines must not keep the last value
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~a;
    o_pwdata <= ~o_pwdata;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] wd);
    logic [7:0] x;
    logic y;
    xfer(1'b1, a, wd, x, y);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d,
      output logic e);
    xfer(1'b0, a, 8'h00, d, e);
  endtask
  // Whole timing set up before any start
  task automatic prog(input logic [7:0] m, input logic [7:0] pl,
      input logic [15:0] r);
    wr({rtu_pkg::IDX_MODE_PRESC_HIGH, 2'b00}, m);
    wr({rtu_pkg::IDX_PRESC_LOW, 2'b00}, pl);
    wr({rtu_pkg::IDX_RELOAD_HIGH, 2'b00}, r[15:8]);
    wr({rtu_pkg::IDX_RELOAD_LOW, 2'b00}, r[7:0]);
  endtask
  task automatic pulse();
    @(posedge i_clk);
    o_tx_end <= 1'b1;
    @(posedge i_clk);
    o_tx_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== rtu_timer_test.sv ====
// Self-checking bench for the timer unit
`timescale 1ns/1ps
`default_nettype none
module rtu_timer_test;
  localparam int RR = rtu_pkg::REF_HZ / rtu_pkg::RATE_GCD;
  localparam int TR = rtu_pkg::TIMER_HZ / rtu_pkg::RATE_GCD;
  localparam logic [9:0] CTL = {rtu_pkg::IDX_CONTROL, 2'b00};
  localparam logic [9:0] STS = {rtu_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] MSK = {rtu_pkg::IDX_IRQ_MASK, 2'b00};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel, pen, pwr, rdy, err, txe, irq, act, e;
  logic [9:0] pa;
  logic [31:0] pwd, prd;
  logic [3:0] strb;
  logic [7:0] d, hi;
  logic [7:0] exp_v [6] = '{8'h9f, 8'ha5, 8'h12, 8'h34, 8'h00, 8'h00};
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int c, lo;
  always #4 clk = ~clk;
  rtu_timer dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .i_pstrb(strb), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err),
    .i_tx_end(txe), .o_expiry_irq(irq), .o_count_active(act));
  rtu_host_model host (.i_clk(clk), .i_pready(rdy), .i_prdata(prd),
    .i_pslverr(err), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
    .o_paddr(pa), .o_pwdata(pwd), .o_pstrb(strb), .o_tx_end(txe));
  function automatic logic [9:0] ba(input logic [7:0] i);
    return {i, 2'b00};
  endfunction
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    num_checks++;
    if (g !== x) begin
      errors++;
      $display("Error %s: expected %h, seen %h", n, x, g);
    end
  endtask
  task automatic chk_rng(input string n, input int a, input int b,
      input logic [15:0] g);
    num_checks++;
    if ((g >= a && g <= b) !== 1'b1) begin
      errors++;
      $display("Error %s: expected %0d..%0d, seen %0d", n, a, b, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Generous ceiling: the sequence needs about 850 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // ********
    // Registers
    // ********
    host.prog(8'hff, 8'ha5, 16'h1234);
    host.wr(ba(8'h2e), 8'h55);
    for (int i = 0; i < 6; i++) begin
      host.rd(ba(8'h2a + i[7:0]), d, e);
      chk($sformatf("reg %0d", i), exp_v[i], d);
    end
    host.rd(ba(8'h40), d, e);
    chk("unmapped data", 8'h00, d);
    chk("unmapped err", 8'h01, {7'h0, e});
    host.rd(ba(8'h2a) + 10'h1, d, e);
    chk("unaligned err", 8'h01, {7'h0, e});
    $display("test registers done");
    // ********
    // Interval and interrupt
    // ********
    host.prog(8'h00, 8'h01, 16'h0003);
    host.wr(MSK, 8'h01);
    host.wr(CTL, 8'h01);
    repeat (3) @(negedge clk);
    chk("active", 8'h01, {7'h0, act});
    c = 3;
    while (act === 1'b1 && c < 500) begin
      @(negedge clk);
      c++;
    end
    lo = 2 + 9 * RR / TR;
    chk_rng("interval", lo, lo + RR / TR + 4, c[15:0]);
    repeat (2) @(negedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    host.rd(STS, d, e);
    chk("status", 8'h03, d);
    host.rd(ba(8'h2e), d, e);
    chk("count after expiry", 8'h00, d);
    host.wr(MSK, 8'h00);
    @(negedge clk);
    chk("irq masked", 8'h00, {7'h0, irq});
    host.wr(MSK, 8'h01);
    @(negedge clk);
    chk("irq unmasked", 8'h01, {7'h0, irq});
    host.wr(STS, 8'h01);
    @(negedge clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    host.rd(STS, d, e);
    chk("status cleared", 8'h02, d);
    $display("test interval done");
    // ********
    // Stop and count readout
    // ********
    host.prog(8'h00, 8'h00, 16'h0100);
    host.wr(CTL, 8'h01);
    repeat (500) @(posedge clk);
    host.wr(CTL, 8'h02);
    repeat (3) @(negedge clk);
    chk("stopped", 8'h00, {7'h0, act});
    host.rd(ba(8'h2e), hi, e);
    host.rd(ba(8'h2f), d, e);
    lo = 256 - 503 * TR / RR;
    chk_rng("count", lo - 3, lo + 3, {hi, d});
    $display("test stop done");
    // ********
    // Start at end of frame
    // ********
    host.prog(8'h00, 8'h00, 16'h0004);
    host.pulse();
    repeat (4) @(negedge clk);
    chk("no auto start", 8'h00, {7'h0, act});
    host.prog(8'h80, 8'h00, 16'h0004);
    host.pulse();
    repeat (3) @(negedge clk);
    chk("auto start", 8'h01, {7'h0, act});
    repeat (100) @(negedge clk);
    chk("auto expired", 8'h00, {7'h0, act});
    $display("test auto start done");
    conclude();
  end
endmodule
`default_nettype wire
